/* File: shared/pwm_timer_defs.svh */
// Offsets, field positions, mode codes and divider counts of the dual-slope PWM timer.
// Assumes a 32-bit APB slave with 8-bit byte addresses.
`ifndef PWM_TIMER_DEFS_SVH
`define PWM_TIMER_DEFS_SVH

// ****************************************************
// Register byte offsets
// ****************************************************
`define OFS_CTRL      8'h00
`define OFS_COUNT     8'h04
`define OFS_CMP_A     8'h08
`define OFS_CMP_B     8'h0C
`define OFS_CAPTOP    8'h10
`define OFS_FLAGS     8'h14

// ****************************************************
// Control field positions
// ****************************************************
`define CTRL_MODE_LO  0
`define CTRL_MODE_HI  3
`define CTRL_COMA_LO  4
`define CTRL_COMA_HI  5
`define CTRL_COMB_LO  6
`define CTRL_COMB_HI  7
`define CTRL_CLK_LO   8
`define CTRL_CLK_HI   10
`define CTRL_DIR_A    11
`define CTRL_DIR_B    12

// ****************************************************
// Flag bit positions (write one to clear)
// ****************************************************
`define FLG_OVF       0
`define FLG_CMPA      1
`define FLG_CMPB      2
`define FLG_CAPT      3

// ****************************************************
// Waveform mode codes and fixed TOP values
// ****************************************************
`define MODE_PC8      4'h1
`define MODE_PC9      4'h2
`define MODE_PC10     4'h3
`define MODE_PFC_CAP  4'h8
`define MODE_PFC_CMP  4'h9
`define MODE_PC_CAP   4'hA
`define MODE_PC_CMP   4'hB
`define TOP_8BIT      16'h00FF
`define TOP_9BIT      16'h01FF
`define TOP_10BIT     16'h03FF
`define TOP_MAX       16'hFFFF
`define CNT_BOTTOM    16'h0000

// ****************************************************
// Compare output modes
// ****************************************************
`define COM_OFF       2'h0
`define COM_TOGGLE    2'h1
`define COM_NONINV    2'h2
`define COM_INV       2'h3

// ****************************************************
// Prescaler terminal counts (factor minus one)
// ****************************************************
`define DIV_1_LAST    10'h000
`define DIV_8_LAST    10'h007
`define DIV_64_LAST   10'h03F
`define DIV_256_LAST  10'h0FF
`define DIV_1024_LAST 10'h3FF

`endif

/* File: shared/pwm_timer_pkg.sv */
// Types of the dual-slope PWM timer: top source and the whole register state.
// Assumes the constants header is on the include path.
`default_nettype none
package pwm_timer_pkg;

  // Where the turning value comes from
  typedef enum logic [1:0] {
    TOP_FIXED,
    TOP_CAPTURE,
    TOP_CMP_A,
    TOP_NONE
  } top_src_t;

  // Entire state of the timer top, one register
  typedef struct packed {
    logic [15:0] count;
    logic        count_up;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] buf_a;
    logic [15:0] buf_b;
    logic [15:0] captop;
    logic [3:0]  mode;
    logic [1:0]  com_a;
    logic [1:0]  com_b;
    logic [2:0]  clk_sel;
    logic        dir_a;
    logic        dir_b;
    logic [3:0]  flags;
    logic [9:0]  pre;
    logic        tick;
    logic        lvl_a;
    logic        lvl_b;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        pin_a;
    logic        oe_a;
    logic        pin_b;
    logic        oe_b;
  } timer_state_t;

endpackage : pwm_timer_pkg
`default_nettype wire

/* File: hdl/pwm_compare_channel.sv */
// Waveform level decision of one compare channel.
// Assumes the caller registers next_level and qualifies it with the timer tick.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_timer_defs.svh"

module pwm_compare_channel (
  input  wire logic       tick,
  input  wire logic       match,
  input  wire logic       count_up,
  input  wire logic [1:0] out_mode,
  input  wire logic       toggle_ok,
  input  wire logic       level,
  output logic            next_level
);

  // ****************************************************
  // Level update on a compare match
  // ****************************************************
  // Non-inverting: match on the rising slope clears, on the falling slope sets; inverting does the reverse
  always_comb begin
    next_level = level;
    if (tick && match) begin
      unique case (out_mode)
        `COM_OFF:    next_level = level;
        `COM_TOGGLE: next_level = toggle_ok ? ~level : level;
        `COM_NONINV: next_level = ~count_up;
        `COM_INV:    next_level = count_up;
      endcase
    end
  end

endmodule : pwm_compare_channel
`default_nettype wire

/* File: hdl/dual_slope_pwm_timer16.sv */
// Dual-slope 16-bit PWM timer with two compare channels behind an APB slave.
// Assumes pclk is the I/O clock and all inputs are synchronous to it.
//
// What this block does
// - Modes 1,2,3,10,11 count 0 up to TOP, then back down, forever.
// - Phase correct TOP: 0x00FF, 0x01FF, 0x03FF, capture top, or channel A compare.
// - Counter holds TOP for one timer tick, then counts down.
// - Mode 2 clears on up-match, sets on down-match; mode 3 inverts that.
// - Phase correct: overflow flag set in the tick the counter is at BOTTOM.
// - Phase correct: compares reload at TOP; TOP source flag set then too.
// - Dual-slope modes: compare flag set in the tick the counter equals that channel's active compare.
// - Fixed TOP: compare writes zero bits above the resolution.
// - Compare at BOTTOM gives steady low, at TOP steady high (non-inverting).
// - Mode 11 with toggle: channel A toggles each match, 50% duty.
// - Modes 8 and 9 count phase and frequency correct; TOP capture or compare A.
// - Frequency correct: compares reload at BOTTOM, overflow flag in that tick.
// - Frequency correct: TOP source flag set when counter reaches TOP.
// - Mode 9 with toggle: channel A toggles each match, 50% duty.
// - Compare output reaches the pin only with its direction bit set.
// - Counter advances on pclk divided by 1, 8, 64, 256 or 1024.
// - Toggle setting drives only channel A in modes 9, 11; else disconnected.
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_timer_defs.svh"

module dual_slope_pwm_timer16 (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             pwm_a_out,
  output logic             pwm_a_oe,
  output logic             pwm_b_out,
  output logic             pwm_b_oe
);
  import pwm_timer_pkg::*;

  timer_state_t st;
  timer_state_t next_st;

  // ****************************************************
  // Mode decode
  // ****************************************************
  top_src_t    top_src;
  logic [15:0] top_val;
  logic        mode_pc;
  logic        mode_pfc;
  logic        dual;
  logic        fixed_top;
  logic        tog_ok_a;
  logic        at_top;
  logic        at_bottom;
  logic        eff_up;
  logic        match_a;
  logic        match_b;
  logic        apb_wr;
  logic        setup;
  logic        mapped;
  logic [15:0] wr_mask;
  logic        lvl_a_n;
  logic        lvl_b_n;
  logic        tick_on;

  // TOP source per mode code
  // Unlisted codes park the counter and leave both pins disconnected
  always_comb begin
    top_val = `TOP_MAX;
    top_src = TOP_NONE;
    unique case (st.mode)
      `MODE_PC8:     begin top_val = `TOP_8BIT;  top_src = TOP_FIXED; end
      `MODE_PC9:     begin top_val = `TOP_9BIT;  top_src = TOP_FIXED; end
      `MODE_PC10:    begin top_val = `TOP_10BIT; top_src = TOP_FIXED; end
      `MODE_PC_CAP,
      `MODE_PFC_CAP: begin top_val = st.captop;  top_src = TOP_CAPTURE; end
      `MODE_PC_CMP,
      `MODE_PFC_CMP: begin top_val = st.cmp_a;   top_src = TOP_CMP_A; end
      default:       begin top_val = `TOP_MAX;   top_src = TOP_NONE; end
    endcase
  end

  assign mode_pc   = (top_src == TOP_FIXED) || (st.mode == `MODE_PC_CAP)
                     || (st.mode == `MODE_PC_CMP);
  assign mode_pfc  = (st.mode == `MODE_PFC_CAP) || (st.mode == `MODE_PFC_CMP);
  assign dual      = mode_pc || mode_pfc;
  assign fixed_top = (top_src == TOP_FIXED);
  assign tog_ok_a  = (st.mode == `MODE_PFC_CMP) || (st.mode == `MODE_PC_CMP);
  assign wr_mask   = fixed_top ? top_val : `TOP_MAX;
  assign tick_on   = st.tick && dual;

  // ****************************************************
  // Slope position and matches
  // ****************************************************
  // TOP counts as falling, BOTTOM as rising, so extreme compares stay steady
  assign at_top    = (st.count == top_val);
  assign at_bottom = (st.count == `CNT_BOTTOM);
  assign eff_up    = at_bottom || (st.count_up && !at_top);
  // A compare above TOP is simply never equal to the count
  assign match_a   = (st.count == st.cmp_a);
  assign match_b   = (st.count == st.cmp_b);

  // ****************************************************
  // Compare channels
  // ****************************************************
  pwm_compare_channel chan_a (
    .tick       (tick_on),
    .match      (match_a),
    .count_up   (eff_up),
    .out_mode   (st.com_a),
    .toggle_ok  (tog_ok_a),
    .level      (st.lvl_a),
    .next_level (lvl_a_n)
  );

  // Channel B never toggles in a dual-slope mode
  pwm_compare_channel chan_b (
    .tick       (tick_on),
    .match      (match_b),
    .count_up   (eff_up),
    .out_mode   (st.com_b),
    .toggle_ok  (1'b0),
    .level      (st.lvl_b),
    .next_level (lvl_b_n)
  );

  // ****************************************************
  // APB decode
  // ****************************************************
  // Zero wait states: pready is simply the registered setup strobe
  // Writes also need pready, so an access phase with no setup is ignored
  assign setup  = psel && !penable;
  assign apb_wr = psel && penable && pwrite && st.pready;
  assign mapped = (paddr == `OFS_CTRL) || (paddr == `OFS_COUNT) || (paddr == `OFS_CMP_A)
                  || (paddr == `OFS_CMP_B) || (paddr == `OFS_CAPTOP)
                  || (paddr == `OFS_FLAGS);

  // ****************************************************
  // Next state
  // ****************************************************
  always_comb begin
    logic [3:0] flag_set;
    logic [3:0] flag_clr;
    logic       conn_a;
    logic       conn_b;
    logic       dual_n;
    next_st  = st;
    flag_set = 4'h0;
    flag_clr = 4'h0;
    conn_a   = 1'b0;
    conn_b   = 1'b0;
    dual_n   = 1'b0;

    // Prescaler: tick is a one-cycle enable, never a clock
    // Selects 6 and 7 stop the timer just like select 0
    next_st.tick = 1'b0;
    unique case (st.clk_sel)
      3'h1:    next_st.tick = (st.pre == `DIV_1_LAST);
      3'h2:    next_st.tick = (st.pre == `DIV_8_LAST);
      3'h3:    next_st.tick = (st.pre == `DIV_64_LAST);
      3'h4:    next_st.tick = (st.pre == `DIV_256_LAST);
      3'h5:    next_st.tick = (st.pre == `DIV_1024_LAST);
      default: next_st.tick = 1'b0;
    endcase
    if (st.clk_sel == 3'h0 || next_st.tick) begin
      next_st.pre = 10'h000;
    end else begin
      next_st.pre = st.pre + 10'h001;
    end

    // Dual-slope counting, one count per tick
    if (tick_on) begin
      if (at_top) begin
        next_st.count_up = 1'b0;
        next_st.count    = st.count - 16'h0001;
      end else if (at_bottom) begin
        next_st.count_up = 1'b1;
        next_st.count    = st.count + 16'h0001;
      end else if (st.count_up) begin
        next_st.count    = st.count + 16'h0001;
      end else begin
        next_st.count    = st.count - 16'h0001;
      end
      if (match_a) flag_set[`FLG_CMPA] = 1'b1;
      if (match_b) flag_set[`FLG_CMPB] = 1'b1;
      if (at_bottom) flag_set[`FLG_OVF] = 1'b1;
      if (at_top && top_src == TOP_CMP_A) flag_set[`FLG_CMPA] = 1'b1;
      if (at_top && top_src == TOP_CAPTURE) flag_set[`FLG_CAPT] = 1'b1;
      // Double-buffered reload point depends on the mode family
      if ((mode_pc && at_top) || (mode_pfc && at_bottom)) begin
        next_st.cmp_a = st.buf_a;
        next_st.cmp_b = st.buf_b;
      end
      next_st.lvl_a = lvl_a_n;
      next_st.lvl_b = lvl_b_n;
    end else if (!dual) begin
      // Outside dual-slope modes the buffers pass straight through
      next_st.cmp_a = st.buf_a;
      next_st.cmp_b = st.buf_b;
    end

    // Register writes, taken at the access edge
    // A COUNT write beats the tick step of the same cycle
    if (apb_wr) begin
      unique case (paddr)
        `OFS_CTRL: begin
          next_st.mode    = pwdata[`CTRL_MODE_HI:`CTRL_MODE_LO];
          next_st.com_a   = pwdata[`CTRL_COMA_HI:`CTRL_COMA_LO];
          next_st.com_b   = pwdata[`CTRL_COMB_HI:`CTRL_COMB_LO];
          next_st.clk_sel = pwdata[`CTRL_CLK_HI:`CTRL_CLK_LO];
          next_st.dir_a   = pwdata[`CTRL_DIR_A];
          next_st.dir_b   = pwdata[`CTRL_DIR_B];
        end
        `OFS_COUNT:  next_st.count  = pwdata[15:0];
        `OFS_CMP_A:  next_st.buf_a  = pwdata[15:0] & wr_mask;
        `OFS_CMP_B:  next_st.buf_b  = pwdata[15:0] & wr_mask;
        `OFS_CAPTOP: next_st.captop = pwdata[15:0];
        `OFS_FLAGS:  flag_clr       = pwdata[3:0];
        default:     next_st.mode   = st.mode;
      endcase
    end
    // A flag raised in the clearing cycle survives
    next_st.flags = (st.flags & ~flag_clr) | flag_set;

    // Read data and answer prepared in the setup cycle
    // Compare registers read back the buffers, not the active values
    next_st.pready  = setup;
    next_st.pslverr = setup && !mapped;
    next_st.prdata  = 32'h0000_0000;
    if (setup && !pwrite) begin
      unique case (paddr)
        `OFS_CTRL:   next_st.prdata = {19'h0, st.dir_b, st.dir_a, st.clk_sel,
                                       st.com_b, st.com_a, st.mode};
        `OFS_COUNT:  next_st.prdata = {16'h0, st.count};
        `OFS_CMP_A:  next_st.prdata = {16'h0, st.buf_a};
        `OFS_CMP_B:  next_st.prdata = {16'h0, st.buf_b};
        `OFS_CAPTOP: next_st.prdata = {16'h0, st.captop};
        `OFS_FLAGS:  next_st.prdata = {28'h0, st.flags};
        default:     next_st.prdata = 32'h0000_0000;
      endcase
    end

    // Pin drive: connected mode and output direction both needed
    // Built from next values so pin and enable move on the same edge
    dual_n = (next_st.mode == `MODE_PC8) || (next_st.mode == `MODE_PC9)
             || (next_st.mode == `MODE_PC10) || (next_st.mode == `MODE_PC_CAP)
             || (next_st.mode == `MODE_PC_CMP) || (next_st.mode == `MODE_PFC_CAP)
             || (next_st.mode == `MODE_PFC_CMP);
    conn_a = dual_n && (next_st.com_a[1] || (next_st.com_a == `COM_TOGGLE
             && (next_st.mode == `MODE_PFC_CMP || next_st.mode == `MODE_PC_CMP)));
    conn_b = dual_n && next_st.com_b[1];
    next_st.oe_a  = conn_a && next_st.dir_a;
    next_st.oe_b  = conn_b && next_st.dir_b;
    next_st.pin_a = next_st.oe_a && next_st.lvl_a;
    next_st.pin_b = next_st.oe_b && next_st.lvl_b;
  end

  // ****************************************************
  // State register
  // ****************************************************
  // Direction resets to up so the first tick leaves BOTTOM upward
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st          <= '0;
      st.count_up <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Every output comes straight from a state flop
  assign prdata    = st.prdata;
  assign pready    = st.pready;
  assign pslverr   = st.pslverr;
  assign pwm_a_out = st.pin_a;
  assign pwm_a_oe  = st.oe_a;
  assign pwm_b_out = st.pin_b;
  assign pwm_b_oe  = st.oe_b;

  // ****************************************************
  // Checks
  // ****************************************************
  // All checks sample on pclk and sleep while reset is low
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  rising_slope_a: assert property (tick_on && st.count_up && !at_top && !apb_wr
    |=> st.count == $past(st.count) + 16'h0001) else $error("count did not rise");
  top_turn_a: assert property (tick_on && at_top && !apb_wr
    |=> !st.count_up && st.count == $past(top_val) - 16'h0001)
    else $error("no turn at top");
  ovf_bottom_a: assert property (tick_on && at_bottom
    |=> st.flags[`FLG_OVF]) else $error("overflow flag missed");
  pc_reload_a: assert property (tick_on && mode_pc && at_top
    |=> st.cmp_a == $past(st.buf_a) && st.cmp_b == $past(st.buf_b))
    else $error("phase correct reload missed");
  pfc_reload_a: assert property (tick_on && mode_pfc && at_bottom
    |=> st.cmp_a == $past(st.buf_a) && st.flags[`FLG_OVF])
    else $error("bottom reload missed");
  pfc_top_flag_a: assert property (tick_on && mode_pfc && at_top && top_src == TOP_CAPTURE
    |=> st.flags[`FLG_CAPT]) else $error("capture top flag missed");
  match_flag_a: assert property (tick_on && match_b
    |=> st.flags[`FLG_CMPB]) else $error("compare flag missed");
  mask_write_a: assert property (apb_wr && paddr == `OFS_CMP_A && fixed_top
    && st.mode == next_st.mode |=> (st.buf_a & ~top_val) == 16'h0000)
    else $error("compare bits not masked");
  noninv_level_a: assert property (tick_on && match_a && st.com_a == `COM_NONINV
    |=> st.lvl_a == !$past(eff_up)) else $error("non-inverting level wrong");
  pin_gate_a: assert property (!st.dir_a || !dual |-> !pwm_a_oe && !pwm_a_out)
    else $error("pin driven without direction");
  tick_pulse_a: assert property (st.tick && st.clk_sel != 3'h1 |=> !st.tick)
    else $error("tick longer than one cycle");
  bottom_low_a: assert property (tick_on && at_bottom && match_a && st.com_a == `COM_NONINV
    |=> !st.lvl_a) else $error("bottom compare not low");
  top_high_a: assert property (tick_on && at_top && !at_bottom && match_b
    && st.com_b == `COM_NONINV |=> st.lvl_b)
    else $error("top compare not high");
  toggle_match_a: assert property (tick_on && match_a && st.com_a == `COM_TOGGLE && tog_ok_a
    |=> st.lvl_a != $past(st.lvl_a)) else $error("channel A did not toggle");
  pc_top_flag_a: assert property (tick_on && mode_pc && at_top && top_src == TOP_CMP_A
    |=> st.flags[`FLG_CMPA]) else $error("compare A top flag missed");
  toggle_b_off_a: assert property (st.com_b == `COM_TOGGLE |-> !pwm_b_oe)
    else $error("channel B driven in toggle setting");

  // ****************************************************
  // Cover points
  // ****************************************************
  // Main scenarios the bench is expected to reach
  top_seen_c: cover property (tick_on && at_top ##[1:600] tick_on && at_bottom);
  toggle_seen_c: cover property (tick_on && match_a && st.com_a == `COM_TOGGLE && tog_ok_a);
  flag_race_c: cover property (apb_wr && paddr == `OFS_FLAGS && tick_on && at_bottom);
  // Live TOP change picked up at BOTTOM in frequency correct mode
  pfc_new_top_c: cover property (tick_on && mode_pfc && at_bottom && st.buf_a != st.cmp_a);

endmodule : dual_slope_pwm_timer16
`default_nettype wire

/* File: tb/dual_slope_pwm_timer16_bench.sv */
// Bench for the dual-slope PWM timer: APB master tasks and one task per scenario.
// Assumes the constants header on the include path; assertions live in the design.
`timescale 1ns/1ps
`default_nettype none
`include "pwm_timer_defs.svh"

module dual_slope_pwm_timer16_bench;
  // ********************
  // Signals and design
  // ********************
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        pwm_a_out;
  logic        pwm_a_oe;
  logic        pwm_b_out;
  logic        pwm_b_oe;
  logic [31:0] rd;
  logic        err;
  int          n_errors;
  int          comparisons;

  dual_slope_pwm_timer16 u_dual_slope_pwm_timer16 (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .pwm_a_out(pwm_a_out), .pwm_a_oe(pwm_a_oe), .pwm_b_out(pwm_b_out), .pwm_b_oe(pwm_b_oe)
  );

  // 250 MHz clock
  initial pclk = 1'b0;
  always #2 pclk = ~pclk;

  // ********************
  // Helpers
  // ********************
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // One transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chk("apb wait", 32'h1, n);
  endtask : apb

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask : rdc

  function automatic logic [31:0] cfg(input logic [3:0] m, input logic [1:0] ca, cb,
                                      input logic [2:0] ck, input logic da, db);
    cfg = {19'h0, db, da, ck, cb, ca, m};
  endfunction : cfg

  // Stop first so compares load straight from the buffers
  task automatic setup(input logic [31:0] ctrl, input logic [15:0] ca, cb, ct);
    apb(1'b1, `OFS_CTRL, 32'h0);
    apb(1'b1, `OFS_COUNT, 32'h0);
    apb(1'b1, `OFS_CMP_A, {16'h0, ca});
    apb(1'b1, `OFS_CMP_B, {16'h0, cb});
    apb(1'b1, `OFS_CAPTOP, {16'h0, ct});
    apb(1'b1, `OFS_FLAGS, 32'hF);
    apb(1'b1, `OFS_CTRL, ctrl);
  endtask : setup

  function automatic logic pin(input logic ch);
    return ch ? pwm_b_out : pwm_a_out;
  endfunction : pin

  // Sampled 1 ns after the edge so the design's updates have landed
  task automatic wait_lvl(input logic ch, input logic v, output int n);
    n = 0;
    while (pin(ch) !== v && n < 6000) begin
      @(posedge pclk);
      #1;
      n++;
    end
  endtask : wait_lvl

  // First partial pulse skipped, then one high and one low span counted
  task automatic meas(input string nm, input logic ch, input int hi, input int lo);
    int n;
    int h;
    int l;
    #1;
    wait_lvl(ch, 1'b0, n);
    wait_lvl(ch, 1'b1, n);
    wait_lvl(ch, 1'b0, h);
    wait_lvl(ch, 1'b1, l);
    chk({nm, " high"}, hi, h);
    chk({nm, " low"}, lo, l);
  endtask : meas

  task automatic steady(input string nm, input logic ch, input logic v, input int n);
    int bad;
    bad = 0;
    repeat (n) begin
      @(posedge pclk);
      #1;
      if (pin(ch) !== v) bad++;
    end
    chk(nm, 32'h0, bad);
  endtask : steady

  // ********************
  // Scenarios
  // ********************
  task automatic s_regs();
    rdc("ctrl rst", `OFS_CTRL, 32'h0);
    rdc("flags rst", `OFS_FLAGS, 32'h0);
    rdc("hole data", 8'h18, 32'h0);
    chk("hole err", 32'h1, {31'h0, err});
  endtask : s_regs

  // Fixed TOPs with compare 2 on both channels, then the write mask
  task automatic s_fixed();
    logic [3:0]  md [3] = '{`MODE_PC8, `MODE_PC9, `MODE_PC10};
    logic [15:0] tp [3] = '{`TOP_8BIT, `TOP_9BIT, `TOP_10BIT};
    for (int i = 0; i < 3; i++) begin
      setup(cfg(md[i], `COM_NONINV, `COM_INV, 3'd1, 1'b1, 1'b1), 16'h2, 16'h2, 16'h0);
      meas("fixed a", 1'b0, 4, 2 * (tp[i] - 2));
      meas("fixed b", 1'b1, 2 * (tp[i] - 2), 4);
      rdc("fixed flags", `OFS_FLAGS, 32'h7);
      apb(1'b1, `OFS_CMP_A, 32'hFFFF);
      rdc("fixed mask", `OFS_CMP_A, {16'h0, tp[i]});
    end
  endtask : s_fixed

  // Smallest legal TOP keeps the slow factors affordable
  task automatic s_prescale();
    int f [5] = '{1, 8, 64, 256, 1024};
    for (int i = 0; i < 5; i++) begin
      setup(cfg(`MODE_PC_CAP, `COM_NONINV, 2'h0, 3'(i + 1), 1'b1, 1'b0), 16'h1, 16'h0, 16'h3);
      meas("prescale", 1'b0, 2 * f[i], 4 * f[i]);
    end
  endtask : s_prescale

  task automatic s_reg_top();
    setup(cfg(`MODE_PC_CAP, `COM_NONINV, `COM_NONINV, 3'd1, 1'b1, 1'b1), 16'h3, 16'h9, 16'h8);
    meas("pc cap", 1'b0, 6, 10);
    steady("above top", 1'b1, pin(1'b1), 40);
    rdc("pc cap flags", `OFS_FLAGS, 32'hB);
    setup(cfg(`MODE_PFC_CAP, 2'h0, `COM_NONINV, 3'd1, 1'b0, 1'b1), 16'h9, 16'h5, 16'h8);
    meas("pfc cap", 1'b1, 10, 6);
    rdc("pfc cap flags", `OFS_FLAGS, 32'hD);
    setup(cfg(`MODE_PFC_CMP, `COM_TOGGLE, `COM_TOGGLE, 3'd1, 1'b1, 1'b1), 16'h6, 16'h2, 16'h0);
    meas("pfc toggle", 1'b0, 12, 12);
    chk("pfc b oe", 32'h0, {31'h0, pwm_b_oe});
    rdc("pfc cmp flags", `OFS_FLAGS, 32'h7);
    setup(cfg(`MODE_PFC_CMP, 2'h0, `COM_NONINV, 3'd1, 1'b0, 1'b1), 16'h6, 16'h2, 16'h0);
    repeat (30) @(posedge pclk);
    apb(1'b1, `OFS_CMP_A, 32'h8);
    meas("pfc new top", 1'b1, 4, 12);
    setup(cfg(`MODE_PC_CMP, `COM_TOGGLE, 2'h0, 3'd1, 1'b1, 1'b0), 16'h6, 16'h0, 16'h0);
    meas("pc toggle", 1'b0, 12, 12);
  endtask : s_reg_top

  // Extreme compares, direction bits and disconnected settings
  task automatic s_pins();
    setup(cfg(`MODE_PC_CAP, `COM_NONINV, `COM_NONINV, 3'd1, 1'b1, 1'b1), 16'h0, 16'h8, 16'h8);
    repeat (20) @(posedge pclk);
    steady("bottom", 1'b0, 1'b0, 40);
    steady("top", 1'b1, 1'b1, 40);
    setup(cfg(`MODE_PC_CAP, `COM_INV, `COM_INV, 3'd1, 1'b1, 1'b1), 16'h8, 16'h0, 16'h8);
    repeat (20) @(posedge pclk);
    steady("top inv", 1'b0, 1'b0, 40);
    steady("bottom inv", 1'b1, 1'b1, 40);
    setup(cfg(`MODE_PC_CAP, `COM_NONINV, `COM_NONINV, 3'd1, 1'b0, 1'b1), 16'h3, 16'h3, 16'h8);
    steady("dir off", 1'b0, 1'b0, 20);
    chk("oe pair", 32'h1, {30'h0, pwm_a_oe, pwm_b_oe});
    setup(cfg(4'h0, `COM_NONINV, `COM_NONINV, 3'd1, 1'b1, 1'b1), 16'h3, 16'h3, 16'h8);
    repeat (3) @(posedge pclk);
    chk("mode 0 oe", 32'h0, {30'h0, pwm_a_oe, pwm_b_oe});
    setup(cfg(`MODE_PC_CAP, `COM_TOGGLE, 2'h0, 3'd1, 1'b1, 1'b1), 16'h3, 16'h3, 16'h8);
    repeat (3) @(posedge pclk);
    chk("toggle cap oe", 32'h0, {31'h0, pwm_a_oe});
  endtask : s_pins

  // ********************
  // Sequence and verdict
  // ********************
  task automatic print_verdict();
    $display("comparisons %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    n_errors = 0;
    comparisons = 0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    s_regs();
    s_fixed();
    s_prescale();
    s_reg_top();
    s_pins();
    print_verdict();
  end

  // Whole run needs about 27k cycles; three times that means a hang
  initial begin
    repeat (80000) @(posedge pclk);
    n_errors++;
    $display("mismatch watchdog expected done seen running");
    print_verdict();
  end
endmodule : dual_slope_pwm_timer16_bench
`default_nettype wire
